// >>> core/mode_regs_pkg.sv
// Constants for the mode and control-channel register bank.
// Assumes a byte-wide register port from the serial control bus slave.
//
// How it works
// RULE1 - Bit 7 reads the map-select strap pin
// RULE2 - Override bit picks strap or register value
// RULE3 - Register value zero LSBs, one MSBs lane three
// RULE4 - Bit 3 reports low-frequency strap level
// RULE5 - Bit 2 reports repeater strap level
// RULE6 - Bit 1 reports legacy compatibility status
// RULE7 - Bit 0 reports audio channel B mode
// RULE8 - Clock-source code picks pixel clock or oscillator
// RULE9 - Low-frequency mode slows oscillator to 12.5 MHz
// RULE10 - Self-test enable bit is read only
// RULE11 - Watchdog aborts transactions that overrun timeout
// RULE12 - Timeout equals field times two milliseconds
// RULE13 - Host never programs timeout field to zero
// RULE14 - Watchdog bit 0 high disables the watchdog
// RULE15 - Pass-all chooses which I2C accesses forward
// RULE16 - Hold field sets SDA hold, 40 ns steps
// RULE17 - Filter field sets glitch width, 5 ns steps
// RULE18 - Reserved bits read zero, writes ignored
`default_nettype none

package mode_regs_pkg;
  localparam logic [7:0] ADDR_GEN_CTRL = 8'h13;
  localparam logic [7:0] ADDR_SELFTEST = 8'h14;
  localparam logic [7:0] ADDR_WATCHDOG = 8'h16;
  localparam logic [7:0] ADDR_I2C_CTRL = 8'h17;

  localparam logic [7:0] RST_GEN_CTRL = 8'h10;
  localparam logic [7:0] RST_SELFTEST = 8'h00;
  localparam logic [7:0] RST_WATCHDOG = 8'hfe;
  localparam logic [7:0] RST_I2C_CTRL = 8'h1e;

  // Writable masks; everything else is reserved or read only
  localparam logic [7:0] WMASK_GEN_CTRL = 8'h60;
  localparam logic [7:0] WMASK_SELFTEST = 8'h06;
  localparam logic [7:0] WMASK_WATCHDOG = 8'hff;
  localparam logic [7:0] WMASK_I2C_CTRL = 8'hff;

  localparam int BIT_MAP_PIN = 7;
  localparam int BIT_MAP_OVR = 6;
  localparam int BIT_MAP_VAL = 5;
  localparam int BIT_LOWFREQ = 3;
  localparam int BIT_REPEAT = 2;
  localparam int BIT_LEGACY = 1;
  localparam int BIT_AUDIO_B = 0;
  localparam int BIT_ST_EN = 0;
  localparam int BIT_WD_DIS = 0;
  localparam int BIT_PASS_ALL = 7;

  localparam logic [1:0] CLKSRC_PIXEL = 2'h0;
  localparam logic [1:0] CLKSRC_OSC = 2'h1;

  // Timing: oscillator domain clock of 40 MHz
  localparam int CLOCK_HZ = 40000000;
  localparam int WD_UNIT_MS = 2;
  localparam int WD_UNIT_CYCLES = CLOCK_HZ / 1000 * WD_UNIT_MS;
  localparam int HOLD_STEP_NS = 40;
  localparam int FILT_STEP_NS = 5;
  localparam int OSC_NOMINAL_KHZ = 33000;
  localparam int OSC_LOWFREQ_KHZ = 12500;

  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_RUN = 2'b01,
    WD_ABORT = 2'b10
  } wd_state_t;
endpackage : mode_regs_pkg

`default_nettype wire

// >>> core/watchdog_timer.sv
// Control-channel watchdog: counts transaction time in 2 ms units.
// Assumes txnActive is a level held for the length of each transaction.
`default_nettype none

module watchdog_timer
  import mode_regs_pkg::*;
#(
  parameter int UNIT_CYCLES = WD_UNIT_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic txnActive,
  input wire logic disable_,
  input wire logic [6:0] timeoutUnits,
  output logic abortPulse
);
  // ==========================================================
  // Counters
  wd_state_t state_reg, state_next;
  logic [31:0] tick_reg, tick_next;
  logic [6:0] units_reg, units_next;
  logic abort_reg, abort_next;

  assign abortPulse = abort_reg;

  always_comb begin
    state_next = state_reg;
    tick_next = tick_reg;
    units_next = units_reg;
    abort_next = 1'b0;
    unique case (state_reg)
      WD_IDLE: begin
        tick_next = '0;
        units_next = '0;
        // RULE14 disable blocks start
        if (txnActive && !disable_) begin
          state_next = WD_RUN;
        end
      end
      WD_RUN: begin
        if (!txnActive || disable_) begin
          state_next = WD_IDLE;
        end else if (tick_reg == 32'(UNIT_CYCLES - 1)) begin
          tick_next = '0;
          units_next = units_reg + 7'h01;
          // RULE12 field times unit
          if (units_reg + 7'h01 >= timeoutUnits) begin
            // RULE11 abort on overrun
            abort_next = 1'b1;
            state_next = WD_ABORT;
          end
        end else begin
          tick_next = tick_reg + 32'h1;
        end
      end
      WD_ABORT: begin
        // Hold until the aborted transaction is released
        if (!txnActive) begin
          state_next = WD_IDLE;
        end
      end
      default: state_next = WD_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= WD_IDLE;
      tick_reg <= '0;
      units_reg <= '0;
      abort_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tick_reg <= tick_next;
      units_reg <= units_next;
      abort_reg <= abort_next;
    end
  end
endmodule : watchdog_timer

`default_nettype wire

// >>> core/mode_ctrl_regs.sv
// Mode, self-test, watchdog and local I2C control register bank.
// Assumes a byte register port driven by the serial control bus slave,
// and strap levels already synchronous to clock.
`default_nettype none

module mode_ctrl_regs
  import mode_regs_pkg::*;
#(
  parameter int WD_UNIT = WD_UNIT_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic laneMapSelectPin,
  input wire logic lowFreqStrap,
  input wire logic repeaterStrap,
  input wire logic legacyCompatStrap,
  input wire logic audioChannelBMode,
  input wire logic selfTestActive,
  input wire logic pixelClockPresent,
  input wire logic oscFallbackEnable,
  input wire logic txnActive,
  input wire logic [6:0] targetId,
  input wire logic [6:0] ownSlaveId,
  input wire logic [6:0] remoteDeserId,
  input wire logic [6:0] remoteSlaveId,
  output logic laneMapMsb,
  output logic useInternalOscillator,
  output logic oscLowRate,
  output logic [31:0] oscFreqKhz,
  output logic txnAbort,
  output logic forwardAccess,
  output logic [8:0] sdaHoldNs,
  output logic [6:0] glitchFilterNs
);
  // ==========================================================
  // Register state
  logic [7:0] genCtrl_reg, genCtrl_next;
  logic [7:0] selfTest_reg, selfTest_next;
  logic [7:0] watchdog_reg, watchdog_next;
  logic [7:0] i2cCtrl_reg, i2cCtrl_next;
  logic [7:0] rdata_reg, rdata_next;
  logic laneMsb_reg, laneMsb_next;
  logic useOsc_reg, useOsc_next;
  logic lowRate_reg, lowRate_next;
  logic [31:0] freq_reg, freq_next;
  logic fwd_reg, fwd_next;
  logic [8:0] hold_reg, hold_next;
  logic [6:0] filt_reg, filt_next;
  logic wdAbort;

  // Masked byte update; reserved and read-only bits never change
  function automatic logic [7:0] masked(input logic [7:0] old,
                                        input logic [7:0] val,
                                        input logic [7:0] mask);
    masked = (old & ~mask) | (val & mask);
  endfunction : masked

  // ==========================================================
  // Write path
  always_comb begin
    genCtrl_next = genCtrl_reg;
    selfTest_next = selfTest_reg;
    watchdog_next = watchdog_reg;
    i2cCtrl_next = i2cCtrl_reg;
    if (regWrite) begin
      unique case (regAddr)
        // RULE18 reserved writes dropped
        ADDR_GEN_CTRL:
          genCtrl_next = masked(genCtrl_reg, regWdata, WMASK_GEN_CTRL);
        ADDR_SELFTEST:
          selfTest_next = masked(selfTest_reg, regWdata, WMASK_SELFTEST);
        ADDR_WATCHDOG:
          watchdog_next = masked(watchdog_reg, regWdata, WMASK_WATCHDOG);
        ADDR_I2C_CTRL:
          i2cCtrl_next = masked(i2cCtrl_reg, regWdata, WMASK_I2C_CTRL);
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    rdata_next = rdata_reg;
    if (regRead) begin
      unique case (regAddr)
        ADDR_GEN_CTRL: begin
          rdata_next = genCtrl_reg & WMASK_GEN_CTRL;
          // RULE1 strap pin level
          rdata_next[BIT_MAP_PIN] = laneMapSelectPin;
          // RULE4 low-frequency strap
          rdata_next[BIT_LOWFREQ] = lowFreqStrap;
          // RULE5 repeater strap
          rdata_next[BIT_REPEAT] = repeaterStrap;
          // RULE6 legacy status
          rdata_next[BIT_LEGACY] = legacyCompatStrap;
          // RULE7 audio B mode
          rdata_next[BIT_AUDIO_B] = audioChannelBMode;
        end
        ADDR_SELFTEST: begin
          rdata_next = selfTest_reg & WMASK_SELFTEST;
          // RULE10 read-only enable
          rdata_next[BIT_ST_EN] = selfTestActive;
        end
        ADDR_WATCHDOG: rdata_next = watchdog_reg;
        ADDR_I2C_CTRL: rdata_next = i2cCtrl_reg;
        // Unmapped addresses in this bank read zero
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Derived controls
  always_comb begin
    // RULE2 override picks source
    if (genCtrl_reg[BIT_MAP_OVR]) begin
      // RULE3 one means MSBs
      laneMsb_next = genCtrl_reg[BIT_MAP_VAL];
    end else begin
      laneMsb_next = laneMapSelectPin;
    end
    // RULE8 clock-source select
    if (selfTestActive) begin
      useOsc_next = (selfTest_reg[2:1] == CLKSRC_OSC);
    end else begin
      useOsc_next = !pixelClockPresent && oscFallbackEnable;
    end
    // RULE9 slower oscillator rate
    lowRate_next = lowFreqStrap;
    freq_next = lowFreqStrap ? 32'(OSC_LOWFREQ_KHZ)
                             : 32'(OSC_NOMINAL_KHZ);
    // RULE15 pass-through filter
    if (targetId == ownSlaveId) begin
      fwd_next = 1'b0;
    end else if (i2cCtrl_reg[BIT_PASS_ALL]) begin
      fwd_next = 1'b1;
    end else begin
      fwd_next = (targetId == remoteDeserId) ||
                 (targetId == remoteSlaveId);
    end
    // RULE16 hold in 40 ns steps
    hold_next = 9'(i2cCtrl_reg[6:4] * HOLD_STEP_NS);
    // RULE17 filter in 5 ns steps
    filt_next = 7'(i2cCtrl_reg[3:0] * FILT_STEP_NS);
  end

  // ==========================================================
  // Watchdog
  // RULE13 zero field aborts after the first unit; host must avoid it
  watchdog_timer #(
    .UNIT_CYCLES(WD_UNIT)
  ) u_watchdog (
    .clock(clock),
    .reset(reset),
    .txnActive(txnActive),
    .disable_(watchdog_reg[BIT_WD_DIS]),
    .timeoutUnits(watchdog_reg[7:1]),
    .abortPulse(wdAbort)
  );

  // ==========================================================
  // Registers
  always_ff @(posedge clock) begin
    if (reset) begin
      genCtrl_reg <= RST_GEN_CTRL & WMASK_GEN_CTRL;
      selfTest_reg <= RST_SELFTEST;
      watchdog_reg <= RST_WATCHDOG;
      i2cCtrl_reg <= RST_I2C_CTRL;
      rdata_reg <= 8'h00;
      laneMsb_reg <= 1'b0;
      useOsc_reg <= 1'b0;
      lowRate_reg <= 1'b0;
      freq_reg <= 32'(OSC_NOMINAL_KHZ);
      fwd_reg <= 1'b0;
      hold_reg <= 9'h000;
      filt_reg <= 7'h00;
    end else begin
      genCtrl_reg <= genCtrl_next;
      selfTest_reg <= selfTest_next;
      watchdog_reg <= watchdog_next;
      i2cCtrl_reg <= i2cCtrl_next;
      rdata_reg <= rdata_next;
      laneMsb_reg <= laneMsb_next;
      useOsc_reg <= useOsc_next;
      lowRate_reg <= lowRate_next;
      freq_reg <= freq_next;
      fwd_reg <= fwd_next;
      hold_reg <= hold_next;
      filt_reg <= filt_next;
    end
  end

  assign regRdata = rdata_reg;
  assign laneMapMsb = laneMsb_reg;
  assign useInternalOscillator = useOsc_reg;
  assign oscLowRate = lowRate_reg;
  assign oscFreqKhz = freq_reg;
  assign txnAbort = wdAbort;
  assign forwardAccess = fwd_reg;
  assign sdaHoldNs = hold_reg;
  assign glitchFilterNs = filt_reg;
endmodule : mode_ctrl_regs

`default_nettype wire

// >>> dv/reg_host.sv
// Host model driving the byte register port of the bank.
// Assumes one access at a time, launched 2 ns after a rising edge.
`default_nettype none

module reg_host (
  input wire logic clock,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {regWrite, regRead, regAddr, regWdata} = 18'h0;
  end
  // ==================================================
  // One access, strobe held across its taking edge
  task xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    if (w && a == 8'h16 && d[7:1] == 7'h0) d[7:1] = 7'h1;
    @(posedge clock);
    #2;
    regAddr = a;
    regWdata = d;
    regWrite = w;
    regRead = !w;
    @(posedge clock);
    #2;
    q = regRdata;
    {regWrite, regRead} = 2'h0;
    // Idle lines flip so stale values never look valid
    regAddr = ~a;
    regWdata = ~d;
  endtask : xfer
endmodule : reg_host

`default_nettype wire

// >>> dv/mode_regs_chk.sv
// Checker for the mode register bank, bound onto its ports.
// Assumes one control transaction at a time and a shrunk watchdog unit.
`default_nettype none

module mode_regs_chk
  import mode_regs_pkg::*;
#(parameter int WD_UNIT = WD_UNIT_CYCLES) (
  input wire logic clock,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic laneMapSelectPin,
  input wire logic lowFreqStrap,
  input wire logic repeaterStrap,
  input wire logic legacyCompatStrap,
  input wire logic audioChannelBMode,
  input wire logic selfTestActive,
  input wire logic txnActive,
  input wire logic [6:0] targetId,
  input wire logic [6:0] ownSlaveId,
  input wire logic [6:0] remoteDeserId,
  input wire logic [6:0] remoteSlaveId,
  input wire logic laneMapMsb,
  input wire logic oscLowRate,
  input wire logic [31:0] oscFreqKhz,
  input wire logic txnAbort,
  input wire logic forwardAccess,
  input wire logic [8:0] sdaHoldNs,
  input wire logic [6:0] glitchFilterNs
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==================================================
  // Shadow of writable fields
  logic [1:0] mapCtl_reg;
  logic [7:0] wdCtl_reg, i2cCtl_reg, genExp;
  logic mapExp, fwdExp;
  logic [8:0] holdExp;
  logic [6:0] filtExp;
  int runCnt_reg, lim;
  assign lim = int'(wdCtl_reg[7:1]) * WD_UNIT;
  assign genExp = {laneMapSelectPin, mapCtl_reg, 1'b0, lowFreqStrap,
    repeaterStrap, legacyCompatStrap, audioChannelBMode};
  assign mapExp = mapCtl_reg[1] ? mapCtl_reg[0] : laneMapSelectPin;
  assign fwdExp = targetId != ownSlaveId && (i2cCtl_reg[7] ||
    targetId == remoteDeserId || targetId == remoteSlaveId);
  assign holdExp = 9'(i2cCtl_reg[6:4]) * 9'h28;
  assign filtExp = 7'(i2cCtl_reg[3:0]) * 7'h5;
  always_ff @(posedge clock) begin
    if (reset) begin
      mapCtl_reg <= 2'h0;
      wdCtl_reg <= RST_WATCHDOG;
      i2cCtl_reg <= RST_I2C_CTRL;
    end else if (regWrite) begin
      if (regAddr == ADDR_GEN_CTRL) mapCtl_reg <= regWdata[6:5];
      if (regAddr == ADDR_WATCHDOG) wdCtl_reg <= regWdata;
      if (regAddr == ADDR_I2C_CTRL) i2cCtl_reg <= regWdata;
    end
  end
  // Counts transaction length; zero outside transactions
  always_ff @(posedge clock) begin
    runCnt_reg <= (txnActive && !reset) ? runCnt_reg + 1 : 0;
  end
  // ==================================================
  // Properties
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  sequence s_rd(logic [7:0] a); regRead && regAddr == a; endsequence
  property p_genRd; s_rd(ADDR_GEN_CTRL) |=> regRdata == $past(genExp);
  endproperty
  a_genRd: assert property (p_genRd) else $error("gen read");
  property p_stRd; s_rd(ADDR_SELFTEST) |=> regRdata[7:3] == 5'h0 &&
    regRdata[0] == $past(selfTestActive); endproperty
  a_stRd: assert property (p_stRd) else $error("test read");
  property p_unmap; regRead && !(regAddr inside {8'h13, 8'h14, 8'h16,
    8'h17}) |=> regRdata == 8'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  property p_map; !$past(reset) |-> laneMapMsb == $past(mapExp); endproperty
  a_map: assert property (p_map) else $error("lane map");
  property p_osc; !$past(reset) |-> oscLowRate == $past(lowFreqStrap) &&
    oscFreqKhz == (oscLowRate ? OSC_LOWFREQ_KHZ : OSC_NOMINAL_KHZ);
  endproperty
  a_osc: assert property (p_osc) else $error("osc rate");
  property p_fwd; !$past(reset) |-> forwardAccess == $past(fwdExp);
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward");
  property p_hold; !$past(reset) |-> sdaHoldNs == $past(holdExp);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_filt; !$past(reset) |-> glitchFilterNs == $past(filtExp);
  endproperty
  a_filt: assert property (p_filt) else $error("filter");
  property p_abT; txnAbort |-> runCnt_reg > lim &&
    runCnt_reg <= lim + 3 && !wdCtl_reg[0]; endproperty
  a_abT: assert property (p_abT) else $error("abort time");
  property p_pulse; txnAbort |=> !txnAbort; endproperty
  a_pulse: assert property (p_pulse) else $error("abort pulse");
endmodule : mode_regs_chk

bind mode_ctrl_regs mode_regs_chk #(.WD_UNIT(WD_UNIT)) chk (.*);

`default_nettype wire

// >>> dv/serializer_mode_and_channel_ctrl_regs_bench.sv
// Bench for the mode register bank: table rows, then directed cases.
// Assumes reg_host drives the register port; watchdog unit cut to 4.
`default_nettype none

module serializer_mode_and_channel_ctrl_regs_bench import mode_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] a, d, e;} row_t;
  logic clock, reset, regWrite, regRead, laneMapSelectPin, lowFreqStrap;
  logic repeaterStrap, legacyCompatStrap, audioChannelBMode, selfTestActive;
  logic pixelClockPresent, oscFallbackEnable, txnActive, laneMapMsb;
  logic useInternalOscillator, oscLowRate, txnAbort, forwardAccess;
  logic [7:0] regAddr, regWdata, regRdata, q;
  logic [6:0] targetId, glitchFilterNs;
  logic [6:0] ownSlaveId = 7'h10, remoteDeserId = 7'h20;
  logic [6:0] remoteSlaveId = 7'h30;
  logic [6:0] ids[4] = '{7'h10, 7'h20, 7'h30, 7'h45};
  logic [8:0] sdaHoldNs;
  logic [31:0] oscFreqKhz;
  logic [15:0] rst[4] = '{16'h1305, 16'h1400, 16'h16fe, 16'h171e};
  int err_total, n_checks, n;
  row_t rows[9] = '{
    '{8'h13, 8'hff, 8'hea}, '{8'h13, 8'h00, 8'h8a},
    '{8'h14, 8'hff, 8'h07}, '{8'h14, 8'h02, 8'h03},
    '{8'h16, 8'h80, 8'h80}, '{8'h16, 8'h02, 8'h02},
    '{8'h17, 8'h7f, 8'h7f}, '{8'h17, 8'h80, 8'h80},
    '{8'h15, 8'hff, 8'h00}};
  reg_host host (.*);
  mode_ctrl_regs #(.WD_UNIT(4)) uut (.*);
  task chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task close_out;
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task cyc(input int c);
    repeat (c) @(posedge clock);
    #2;
  endtask : cyc
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    {err_total, n_checks} = 0;
    {reset, laneMapSelectPin, lowFreqStrap, repeaterStrap,
      legacyCompatStrap, audioChannelBMode, selfTestActive} = 7'h75;
    {pixelClockPresent, oscFallbackEnable, txnActive, targetId} = 10'h0;
    cyc(12);
    reset = 1'b0;
    foreach (rows[i]) begin
      host.xfer(1'b1, rows[i].a, rows[i].d, q);
      host.xfer(1'b0, rows[i].a, 8'h0, q);
      chk(32'(q), 32'(rows[i].e));
    end
    for (int k = 0; k < 4; k++) begin
      laneMapSelectPin = k[0];
      host.xfer(1'b1, 8'h13, {1'b0, k[1], k[0] ^ k[1], 5'h0}, q);
      cyc(3);
      chk(32'(laneMapMsb), 32'(k[0] ^ k[1]));
    end
    for (int k = 0; k < 8; k++) begin
      host.xfer(1'b1, 8'h17, {k[2], 7'h7f}, q);
      targetId = ids[k[1:0]];
      cyc(3);
      chk(32'(forwardAccess), 32'((8'he6 >> k) & 8'h01));
    end
    chk(32'(sdaHoldNs), 32'h118);
    chk(32'(glitchFilterNs), 32'h4b);
    oscFallbackEnable = 1'b1;
    for (int k = 0; k < 4; k++) begin
      selfTestActive = !k[1];
      {pixelClockPresent, lowFreqStrap} = {2{k[0]}};
      host.xfer(1'b1, 8'h14, {6'h0, k[0] | k[1], 1'b0}, q);
      cyc(3);
      chk(32'(useInternalOscillator), 32'(k[0] ^ k[1]));
      chk(oscFreqKhz, k[0] ? OSC_LOWFREQ_KHZ : OSC_NOMINAL_KHZ);
      chk(32'(oscLowRate), 32'(k[0]));
    end
    for (int k = 1; k < 3; k++) begin
      host.xfer(1'b1, 8'h16, 8'(2 * k), q);
      txnActive = 1'b1;
      n = 0;
      while (txnAbort !== 1'b1 && n < 40) begin
        cyc(1);
        n++;
      end
      if (n >= 40) begin
        chk(32'(txnAbort), 32'h1);
        close_out;
      end
      chk(32'(n > 4 * k && n <= 4 * k + 3), 32'h1);
      cyc(1);
      chk(32'(txnAbort), 32'h0);
      txnActive = 1'b0;
      cyc(2);
    end
    host.xfer(1'b1, 8'h16, 8'h03, q);
    txnActive = 1'b1;
    n = 0;
    repeat (20) begin
      cyc(1);
      if (txnAbort !== 1'b0) n++;
    end
    chk(32'(n), 32'h0);
    txnActive = 1'b0;
    {reset, laneMapSelectPin, lowFreqStrap, repeaterStrap,
      legacyCompatStrap, audioChannelBMode, selfTestActive} = 7'h4a;
    cyc(2);
    reset = 1'b0;
    foreach (rst[i]) begin
      host.xfer(1'b0, rst[i][15:8], 8'h0, q);
      chk(32'(q), 32'(rst[i][7:0]));
    end
    chk(32'(sdaHoldNs), 32'h28);
    chk(32'(glitchFilterNs), 32'h46);
    close_out;
  end
endmodule : serializer_mode_and_channel_ctrl_regs_bench

`default_nettype wire
